// ---- hdl/prsdc_pkg.sv ----
package prsdc_pkg;
	localparam logic [31:0] CFG_CS1_ADDR = 32'hffff_f4a4;
	localparam logic [31:0] CFG_CS3_ADDR = 32'hffff_f4ac;
	localparam logic [31:0] CFG_CS4_ADDR = 32'hffff_f4b0;
	localparam logic [31:0] CFG_CS6_ADDR = 32'hffff_f4b8;
	localparam logic [31:0] PROM_CFG_ADDR = 32'hffff_f4c0;
	localparam logic [31:0] CTRL_ADDR = 32'hffff_f4c4;
	localparam logic [15:0] SCR_RESET = 16'h30c0;
	localparam logic [15:0] PROM_CFG_RESET = 16'h7000;
	localparam logic [15:0] SCR_WMASK = 16'h70ff;
	localparam logic [15:0] PROM_CFG_WMASK = 16'h700f;
	localparam int SCR_DONE_BIT = 8;
	localparam int MEM_EN_LSB = 0;
	localparam int SPEC_LSB = 8;
	localparam logic [1:0] ACT_WAIT_DEF = 2'h1;
	localparam logic [15:0] REFRESH_INTERVAL = 16'h0600;
	typedef enum {PRSDC_IDLE, PRSDC_PREALL, PRSDC_MRS, PRSDC_READY, PRSDC_PRE, PRSDC_ACT,
		PRSDC_WAIT, PRSDC_CMD, PRSDC_LAT, PRSDC_PREOLD, PRSDC_REF, PRSDC_SELF} prsdc_state_t;
	typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREALL,
		CMD_MRS, CMD_REF} prsdc_cmd_t;
	typedef struct packed {
		logic [1:0] cs_idx;
		logic [1:0] bank;
		logic [12:0] row;
		logic [10:0] col;
		logic write;
	} prsdc_sd_req_t;
endpackage

// ---- hdl/prsdc_ctrl.sv ----
`timescale 1ns/1ps
module prsdc_ctrl (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic ROM_REQ,
	input wire logic [2:0] ROM_CS,
	input wire logic [25:0] ROM_ADDR,
	output logic ROM_ON_PAGE,
	output logic [2:0] ROM_WAITS,
	input wire logic SD_REQ,
	input wire logic [1:0] SD_CS,
	input wire logic [25:0] SD_ADDR,
	input wire logic SD_WRITE,
	input wire logic SD_FLYBY,
	output logic SD_GRANT,
	output logic SD_DONE,
	output logic [2:0] SD_CMD,
	output logic [12:0] SD_ROW,
	output logic [10:0] SD_COL,
	output logic [1:0] SD_BANK,
	output logic [1:0] SD_CAS_LAT,
	output logic SD_CKE,
	input wire logic SELF_REF_REQ
);
	logic [15:0] scr_q [4];
	logic [15:0] scr_d [4];
	logic [15:0] prom_cfg_q, prom_cfg_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [3:0] done_q, done_d;
	logic wr_pend_q, wr_pend_d;
	logic flyby_q, flyby_d;
	logic [31:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic rom_valid_q, rom_valid_d;
	logic [2:0] rom_cs_q, rom_cs_d;
	logic [25:0] rom_addr_q, rom_addr_d;
	logic rom_on_q, rom_on_d;
	logic [2:0] rom_wait_q, rom_wait_d;
	prsdc_pkg::prsdc_state_t st_q, st_d;
	logic [2:0] cmd_q, cmd_d;
	logic [1:0] cnt_q, cnt_d;
	logic [1:0] mrs_idx_q, mrs_idx_d;
	logic [3:0] open_q, open_d;
	logic [12:0] open_row_q [4];
	logic [12:0] open_row_d [4];
	logic [1:0] old_bank_q, old_bank_d;
	logic [15:0] ref_cnt_q, ref_cnt_d;
	logic grant_q, grant_d, sd_done_q, sd_done_d;
	prsdc_pkg::prsdc_sd_req_t req_q, req_d;
	logic [3:0] rom_ma;
	logic [25:0] rom_cmp_mask;
	logic [1:0] cur_lat;
	logic [1:0] eff_lat;
	logic [15:0] rsel;

	function automatic logic [1:0] lat_decode(input logic [2:0] code);
		case (code)
			3'h1: lat_decode = 2'h1;
			3'h2: lat_decode = 2'h2;
			3'h3: lat_decode = 2'h3;
			default: lat_decode = 2'h2;
		endcase
	endfunction

	function automatic logic [1:0] wait_decode(input logic [1:0] code);
		wait_decode = (code == 2'h0) ? prsdc_pkg::ACT_WAIT_DEF : code;
	endfunction

	function automatic int reg_index(input logic [31:0] a);
		case (a)
			prsdc_pkg::CFG_CS1_ADDR: reg_index = 0;
			prsdc_pkg::CFG_CS3_ADDR: reg_index = 1;
			prsdc_pkg::CFG_CS4_ADDR: reg_index = 2;
			prsdc_pkg::CFG_CS6_ADDR: reg_index = 3;
			prsdc_pkg::PROM_CFG_ADDR: reg_index = 4;
			prsdc_pkg::CTRL_ADDR: reg_index = 5;
			default: reg_index = 6;
		endcase
	endfunction

	// Address split: column low, then row, bank above
	function automatic prsdc_pkg::prsdc_sd_req_t split(input logic [25:0] a,
		input logic [15:0] cfg, input logic [1:0] idx, input logic wr);
		prsdc_pkg::prsdc_sd_req_t r;
		logic [25:0] s;
		logic [3:0] cw;
		logic [3:0] rw;
		s = a >> cfg[5:4];
		cw = 4'(8 + cfg[1:0]);
		rw = 4'(11 + ((cfg[3:2] == 2'h3) ? 2'h0 : cfg[3:2]));
		r.cs_idx = idx;
		r.write = wr;
		r.col = 11'(s & ((26'h1 << cw) - 26'h1));
		r.row = 13'((s >> cw) & ((26'h1 << rw) - 26'h1));
		r.bank = 2'((s >> (5'(cw) + 5'(rw))) & 26'h3);
		split = r;
	endfunction

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = rdata_q;
	assign ROM_ON_PAGE = rom_on_q;
	assign ROM_WAITS = rom_wait_q;
	assign SD_CMD = cmd_q;
	assign SD_GRANT = grant_q;
	assign SD_DONE = sd_done_q;
	assign SD_ROW = req_q.row;
	assign SD_COL = req_q.col;
	assign SD_BANK = (st_q == prsdc_pkg::PRSDC_PREOLD) ? old_bank_q : req_q.bank;
	assign SD_CAS_LAT = eff_lat;
	assign SD_CKE = (st_q != prsdc_pkg::PRSDC_SELF);

	assign cur_lat = lat_decode(scr_q[req_q.cs_idx][14:12]);
	assign eff_lat = (flyby_q && cur_lat == 2'h1) ? 2'h2 : cur_lat;
	assign rom_ma = prom_cfg_q[3:0];
	assign rom_cmp_mask = ~{19'h0, rom_ma, 3'h0};
	always_comb begin
		rsel = 16'h0;
		case (reg_index(HADDR))
			0, 1, 2, 3: rsel = scr_q[reg_index(HADDR)];
			4: rsel = prom_cfg_q;
			5: rsel = ctrl_q;
			default: rsel = 16'h0;
		endcase
	end

	// Register bus
	always_comb begin
		logic take;
		take = HSEL && HREADY && HTRANS[1];
		wr_pend_d = take && HWRITE;
		addr_d = take ? HADDR : addr_q;
		rdata_d = rdata_q;
		prom_cfg_d = prom_cfg_q;
		ctrl_d = ctrl_q;
		for (int i = 0; i < 4; i++) begin
			scr_d[i] = scr_q[i];
		end
		// Read data stands through the data phase
		if (take && !HWRITE) begin
			rdata_d = {16'h0, rsel};
		end
		if (wr_pend_q) begin
			case (reg_index(addr_q))
				0, 1, 2, 3: scr_d[reg_index(addr_q)] = HWDATA[15:0] & prsdc_pkg::SCR_WMASK;
				4: prom_cfg_d = HWDATA[15:0] & prsdc_pkg::PROM_CFG_WMASK;
				5: ctrl_d = {4'h0, HWDATA[11:8], 4'h0, HWDATA[3:0]};
				default: ;
			endcase
		end
		for (int i = 0; i < 4; i++) begin
			scr_d[i][prsdc_pkg::SCR_DONE_BIT] = done_q[i];
		end
	end

	// Page ROM judgment
	always_comb begin
		logic spec;
		spec = ctrl_q[prsdc_pkg::SPEC_LSB + 1];
		rom_valid_d = rom_valid_q;
		rom_cs_d = rom_cs_q;
		rom_addr_d = rom_addr_q;
		rom_on_d = rom_on_q;
		rom_wait_d = rom_wait_q;
		if (ROM_REQ) begin
			rom_on_d = rom_valid_q && (rom_cs_q == ROM_CS)
				&& (((rom_addr_q ^ ROM_ADDR) & rom_cmp_mask & 26'h3ff_fff8) == 26'h0);
			if (!spec) begin
				rom_on_d = 1'b0;
			end
			rom_wait_d = rom_on_d ? prom_cfg_q[14:12] : 3'h0;
			rom_valid_d = 1'b1;
			rom_cs_d = ROM_CS;
			rom_addr_d = ROM_ADDR;
		end
	end

	// SDRAM sequencer
	always_comb begin
		st_d = st_q;
		cmd_d = prsdc_pkg::CMD_NOP;
		cnt_d = (cnt_q != 2'h0) ? cnt_q - 2'h1 : 2'h0;
		mrs_idx_d = mrs_idx_q;
		open_d = open_q;
		old_bank_d = old_bank_q;
		req_d = req_q;
		flyby_d = flyby_q;
		grant_d = 1'b0;
		sd_done_d = 1'b0;
		done_d = done_q;
		ref_cnt_d = ref_cnt_q + 16'h1;
		for (int i = 0; i < 4; i++) begin
			open_row_d[i] = open_row_q[i];
		end
		for (int i = 0; i < 4; i++) begin
			if (!ctrl_q[prsdc_pkg::MEM_EN_LSB + i] || (wr_pend_q && reg_index(addr_q) == i)) begin
				done_d[i] = 1'b0;
			end
		end
		case (st_q)
			prsdc_pkg::PRSDC_IDLE: begin
				cmd_d = prsdc_pkg::CMD_PREALL;
				open_d = 4'h0;
				st_d = prsdc_pkg::PRSDC_PREALL;
			end
			prsdc_pkg::PRSDC_PREALL: begin
				st_d = prsdc_pkg::PRSDC_READY;
			end
			prsdc_pkg::PRSDC_MRS: begin
				cmd_d = prsdc_pkg::CMD_MRS;
				done_d[mrs_idx_q] = 1'b1;
				st_d = prsdc_pkg::PRSDC_READY;
			end
			prsdc_pkg::PRSDC_READY: begin
				if (SELF_REF_REQ && open_q != 4'h0) begin
					// Close all banks before self refresh
					cmd_d = prsdc_pkg::CMD_PREALL;
					open_d = 4'h0;
				end else if (SELF_REF_REQ) begin
					cmd_d = prsdc_pkg::CMD_REF;
					st_d = prsdc_pkg::PRSDC_SELF;
				end else if (ref_cnt_q >= prsdc_pkg::REFRESH_INTERVAL) begin
					cmd_d = prsdc_pkg::CMD_PREALL;
					ref_cnt_d = 16'h0;
					st_d = prsdc_pkg::PRSDC_REF;
				end else if (|(ctrl_q[3:0] & ~done_q)) begin
					for (int i = 3; i >= 0; i--) begin
						if (ctrl_q[i] && !done_q[i]) begin
							mrs_idx_d = 2'(i);
						end
					end
					st_d = prsdc_pkg::PRSDC_MRS;
				end else if (SD_REQ && done_q[SD_CS]) begin
					req_d = split(SD_ADDR, scr_q[SD_CS], SD_CS, SD_WRITE);
					grant_d = 1'b1;
					flyby_d = SD_FLYBY;
					if (open_d[req_d.bank] && open_row_q[req_d.bank] == req_d.row) begin
						st_d = prsdc_pkg::PRSDC_CMD;
					end else if (open_q[req_d.bank]) begin
						st_d = prsdc_pkg::PRSDC_PRE;
					end else begin
						st_d = prsdc_pkg::PRSDC_ACT;
					end
				end
			end
			prsdc_pkg::PRSDC_PRE: begin
				cmd_d = prsdc_pkg::CMD_PRE;
				open_d[req_q.bank] = 1'b0;
				cnt_d = wait_decode(scr_q[req_q.cs_idx][7:6]);
				st_d = prsdc_pkg::PRSDC_WAIT;
			end
			prsdc_pkg::PRSDC_ACT: begin
				cmd_d = prsdc_pkg::CMD_ACT;
				old_bank_d = req_q.bank;
				for (int i = 0; i < 4; i++) begin
					if (open_q[i] && 2'(i) != req_q.bank) begin
						old_bank_d = 2'(i);
					end
				end
				open_d[req_q.bank] = 1'b1;
				open_row_d[req_q.bank] = req_q.row;
				cnt_d = wait_decode(scr_q[req_q.cs_idx][7:6]);
				st_d = prsdc_pkg::PRSDC_WAIT;
			end
			prsdc_pkg::PRSDC_WAIT: begin
				if (cnt_q == 2'h1) begin
					st_d = open_q[req_q.bank] ? prsdc_pkg::PRSDC_CMD : prsdc_pkg::PRSDC_ACT;
				end
			end
			prsdc_pkg::PRSDC_CMD: begin
				cmd_d = req_q.write ? prsdc_pkg::CMD_WR : prsdc_pkg::CMD_RD;
				cnt_d = eff_lat;
				st_d = req_q.write ? prsdc_pkg::PRSDC_LAT : prsdc_pkg::PRSDC_LAT;
			end
			prsdc_pkg::PRSDC_LAT: begin
				if (cnt_q <= 2'h1 || req_q.write) begin
					sd_done_d = 1'b1;
					st_d = (old_bank_q != req_q.bank && open_q[old_bank_q])
						? prsdc_pkg::PRSDC_PREOLD : prsdc_pkg::PRSDC_READY;
				end
			end
			prsdc_pkg::PRSDC_PREOLD: begin
				cmd_d = prsdc_pkg::CMD_PRE;
				open_d[old_bank_q] = 1'b0;
				old_bank_d = req_q.bank;
				st_d = prsdc_pkg::PRSDC_READY;
			end
			prsdc_pkg::PRSDC_REF: begin
				cmd_d = prsdc_pkg::CMD_REF;
				open_d = 4'h0;
				st_d = prsdc_pkg::PRSDC_READY;
			end
			prsdc_pkg::PRSDC_SELF: begin
				if (!SELF_REF_REQ) begin
					cmd_d = prsdc_pkg::CMD_PREALL;
					open_d = 4'h0;
					st_d = prsdc_pkg::PRSDC_PREALL;
				end
			end
			default: st_d = prsdc_pkg::PRSDC_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++) begin
				scr_q[i] <= prsdc_pkg::SCR_RESET;
				open_row_q[i] <= 13'h0;
			end
			prom_cfg_q <= prsdc_pkg::PROM_CFG_RESET;
			ctrl_q <= 16'h0;
			done_q <= 4'h0;
			wr_pend_q <= 1'b0;
			flyby_q <= 1'b0;
			addr_q <= 32'h0;
			rdata_q <= 32'h0;
			rom_valid_q <= 1'b0;
			rom_cs_q <= 3'h0;
			rom_addr_q <= 26'h0;
			rom_on_q <= 1'b0;
			rom_wait_q <= 3'h0;
			st_q <= prsdc_pkg::PRSDC_IDLE;
			cmd_q <= prsdc_pkg::CMD_NOP;
			cnt_q <= 2'h0;
			mrs_idx_q <= 2'h0;
			open_q <= 4'h0;
			old_bank_q <= 2'h0;
			ref_cnt_q <= 16'h0;
			grant_q <= 1'b0;
			sd_done_q <= 1'b0;
			req_q <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				scr_q[i] <= scr_d[i];
				open_row_q[i] <= open_row_d[i];
			end
			prom_cfg_q <= prom_cfg_d;
			ctrl_q <= ctrl_d;
			done_q <= done_d;
			wr_pend_q <= wr_pend_d;
			flyby_q <= flyby_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			rom_valid_q <= rom_valid_d;
			rom_cs_q <= rom_cs_d;
			rom_addr_q <= rom_addr_d;
			rom_on_q <= rom_on_d;
			rom_wait_q <= rom_wait_d;
			st_q <= st_d;
			cmd_q <= cmd_d;
			cnt_q <= cnt_d;
			mrs_idx_q <= mrs_idx_d;
			open_q <= open_d;
			old_bank_q <= old_bank_d;
			ref_cnt_q <= ref_cnt_d;
			grant_q <= grant_d;
			sd_done_q <= sd_done_d;
			req_q <= req_d;
		end
	end
endmodule

// ---- verification/prsdc_ctrl_chk.sv ----
`timescale 1ns/1ps
module prsdc_ctrl_chk (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic ROM_REQ,
	input wire logic [2:0] ROM_CS,
	input wire logic [25:0] ROM_ADDR,
	input wire logic ROM_ON_PAGE,
	input wire logic [2:0] ROM_WAITS,
	input wire logic SD_GRANT,
	input wire logic SD_DONE,
	input wire logic [2:0] SD_CMD,
	input wire logic SD_FLYBY,
	input wire logic [1:0] SD_CAS_LAT,
	input wire logic SD_CKE,
	input wire logic SELF_REF_REQ
);
	logic [2:0] cs_q;
	logic [25:0] addr_q;
	logic mrs_q;
	// Last page ROM cycle and whether a mode write was seen
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cs_q <= 3'h0;
			addr_q <= 26'h000_0000;
			mrs_q <= 1'b0;
		end else begin
			if (ROM_REQ) begin
				cs_q <= ROM_CS;
				addr_q <= ROM_ADDR;
			end
			if (SD_CMD == prsdc_pkg::CMD_MRS)
				mrs_q <= 1'b1;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	property p_off_wait; !ROM_ON_PAGE |-> ROM_WAITS == 3'h0; endproperty
	a_off_wait: assert property (p_off_wait)
		else $error("wait count on off-page cycle");
	property p_cs_chg; ROM_REQ && ROM_CS != cs_q |=> !ROM_ON_PAGE; endproperty
	a_cs_chg: assert property (p_cs_chg)
		else $error("chip select change judged on-page");
	property p_addr_chg; ROM_REQ && ROM_ADDR[25:7] != addr_q[25:7] |=> !ROM_ON_PAGE; endproperty
	a_addr_chg: assert property (p_addr_chg)
		else $error("upper address change judged on-page");
	property p_hold; !ROM_REQ |=> $stable(ROM_ON_PAGE); endproperty
	a_hold: assert property (p_hold)
		else $error("page verdict changed without a request");
	property p_preall; $rose(RST_N) |-> ##[0:1] SD_CMD == prsdc_pkg::CMD_PREALL; endproperty
	a_preall: assert property (p_preall)
		else $error("no precharge all after reset");
	property p_mrs_first; SD_CMD inside {prsdc_pkg::CMD_RD, prsdc_pkg::CMD_WR} |-> mrs_q; endproperty
	a_mrs_first: assert property (p_mrs_first)
		else $error("read or write before mode write");
	property p_act_cmd; SD_CMD == prsdc_pkg::CMD_ACT |-> ##[2:4] SD_CMD inside {2, 3}; endproperty
	a_act_cmd: assert property (p_act_cmd)
		else $error("activate not followed by access in time");
	property p_lat; SD_GRANT |-> SD_CAS_LAT != 2'h0 && !(SD_FLYBY && SD_CAS_LAT == 2'h1); endproperty
	a_lat: assert property (p_lat)
		else $error("illegal latency at grant");
	property p_done; SD_GRANT |-> ##[1:20] SD_DONE; endproperty
	a_done: assert property (p_done)
		else $error("access not finished in time");
	property p_cke; $rose(SELF_REF_REQ) |-> ##[1:40] !SD_CKE; endproperty
	a_cke: assert property (p_cke)
		else $error("self refresh not entered");
	c_on_page: cover property (ROM_REQ ##1 ROM_ON_PAGE);
	c_access: cover property (SD_GRANT ##[1:20] SD_DONE);
	c_self: cover property (!SD_CKE);
endmodule

// ---- verification/prsdc_sdram_mdl.sv ----
`timescale 1ns/1ps
module prsdc_sdram_mdl (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [2:0] SD_CMD,
	input wire logic [1:0] SD_BANK,
	output int bad
);
	logic [3:0] open_q;
	logic ready_q;
	initial bad = 0;
	always @(posedge MCLK) begin
		if (!RST_N) begin
			open_q <= 4'hf;
			ready_q <= 1'b0;
		end else case (SD_CMD)
			prsdc_pkg::CMD_ACT: begin
				if (!ready_q) bad <= bad + 1;
				open_q[SD_BANK] <= 1'b1;
			end
			prsdc_pkg::CMD_RD, prsdc_pkg::CMD_WR: if (!ready_q || !open_q[SD_BANK]) bad <= bad + 1;
			prsdc_pkg::CMD_PRE: open_q[SD_BANK] <= 1'b0;
			prsdc_pkg::CMD_PREALL: begin
				open_q <= 4'h0;
				ready_q <= 1'b1;
			end
			prsdc_pkg::CMD_REF: if (open_q != 4'h0) bad <= bad + 1;
			default: ;
		endcase
	end
endmodule

// ---- verification/prsdc_ctrl_test.sv ----
`timescale 1ns/1ps
module prsdc_ctrl_test;
	logic MCLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, HREADY, HREADYOUT, HRESP;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
	logic [1:0] HTRANS = 0, SD_CS = 0, SD_BANK, SD_CAS_LAT;
	logic [2:0] HSIZE = 3'h2, ROM_CS = 0, ROM_WAITS, SD_CMD;
	logic ROM_REQ = 0, ROM_ON_PAGE, SD_REQ = 0, SD_WRITE = 0, SD_FLYBY = 0;
	logic SD_GRANT, SD_DONE, SD_CKE, SELF_REF_REQ = 0;
	logic [25:0] ROM_ADDR = 0, SD_ADDR = 0;
	logic [12:0] SD_ROW;
	logic [10:0] SD_COL;
	int err_total = 0, comparisons = 0, bad;
	logic [31:0] scr_a[4] = '{prsdc_pkg::CFG_CS1_ADDR, prsdc_pkg::CFG_CS3_ADDR,
		prsdc_pkg::CFG_CS4_ADDR, prsdc_pkg::CFG_CS6_ADDR};
	logic [15:0] cfg[4] = '{16'h1041, 16'h20d6, 16'h3080, 16'h0120};
	logic [1:0] lat[4] = '{2'h1, 2'h2, 2'h3, 2'h2};
	assign HREADY = HREADYOUT;
	always #2 MCLK = ~MCLK;
	prsdc_ctrl i_prsdc_ctrl (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ROM_REQ(ROM_REQ),
		.ROM_CS(ROM_CS), .ROM_ADDR(ROM_ADDR), .ROM_ON_PAGE(ROM_ON_PAGE), .ROM_WAITS(ROM_WAITS),
		.SD_REQ(SD_REQ), .SD_CS(SD_CS), .SD_ADDR(SD_ADDR), .SD_WRITE(SD_WRITE),
		.SD_FLYBY(SD_FLYBY), .SD_GRANT(SD_GRANT), .SD_DONE(SD_DONE), .SD_CMD(SD_CMD),
		.SD_ROW(SD_ROW), .SD_COL(SD_COL), .SD_BANK(SD_BANK), .SD_CAS_LAT(SD_CAS_LAT),
		.SD_CKE(SD_CKE), .SELF_REF_REQ(SELF_REF_REQ));
	prsdc_sdram_mdl i_prsdc_sdram_mdl (.MCLK(MCLK), .RST_N(RST_N), .SD_CMD(SD_CMD),
		.SD_BANK(SD_BANK), .bad(bad));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		HSIZE <= 3'h2;
		do @(posedge MCLK); while (HREADY !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge MCLK); while (HREADY !== 1'b1);
		rd = HRDATA;
		HSEL <= 1'b0;
		@(posedge MCLK);
	endtask
	task automatic poll(input logic [31:0] a, input logic [31:0] e);
		int n;
		n = 0;
		do begin bus(1'b0, a, 32'h0); n++; end while (rd[8] !== 1'b1 && n < 50);
		chk("scr_done", e, rd);
	endtask
	task automatic rom(input logic [2:0] c, input logic [25:0] a, input logic on);
		ROM_REQ <= 1'b1;
		ROM_CS <= c;
		ROM_ADDR <= a;
		@(posedge MCLK);
		ROM_REQ <= 1'b0;
		@(posedge MCLK);
		chk("rom_on_page", {31'h0, on}, {31'h0, ROM_ON_PAGE});
		chk("rom_waits", on ? 32'h5 : 32'h0, {29'h0, ROM_WAITS});
	endtask
	task automatic sd(input logic [1:0] c, input logic [25:0] a, input logic w, input logic f,
		input logic [1:0] l);
		int n, s, cw, rw;
		SD_REQ <= 1'b1;
		SD_CS <= c;
		SD_ADDR <= a;
		SD_WRITE <= w;
		SD_FLYBY <= f;
		n = 0;
		do begin @(posedge MCLK); n++; end while (SD_GRANT !== 1'b1 && n < 200);
		chk("sd_grant", 1, SD_GRANT);
		chk("cas_latency", l, SD_CAS_LAT);
		s = int'(a) >> cfg[c][5:4];
		cw = 8 + int'(cfg[c][1:0]);
		rw = 11 + int'(cfg[c][3:2]);
		chk("sd_col", s % (1 << cw), SD_COL);
		chk("sd_row", (s >> cw) % (1 << rw), SD_ROW);
		chk("sd_bank", (s >> (cw + rw)) % 4, SD_BANK);
		SD_REQ <= 1'b0;
		n = 0;
		do begin @(posedge MCLK); n++; end while (SD_DONE !== 1'b1 && n < 40);
		chk("sd_done", 1, SD_DONE);
	endtask
	task automatic t_reset;
		foreach (scr_a[i]) begin
			bus(1'b0, scr_a[i], 32'h0);
			chk("scr_reset", {16'h0, prsdc_pkg::SCR_RESET}, rd);
		end
		bus(1'b0, prsdc_pkg::PROM_CFG_ADDR, 32'h0);
		chk("prom_cfg_reset", {16'h0, prsdc_pkg::PROM_CFG_RESET}, rd);
		bus(1'b0, 32'hffff_f4a8, 32'h0);
		chk("unmapped", 0, rd);
		chk("hresp_okay", 0, {31'h0, HRESP});
		$display("test reset values done");
	endtask
	task automatic t_cfg;
		bus(1'b1, prsdc_pkg::CTRL_ADDR, 32'h0);
		foreach (scr_a[i]) bus(1'b1, scr_a[i], {16'h0, cfg[i]});
		foreach (scr_a[i]) begin
			bus(1'b0, scr_a[i], 32'h0);
			chk("scr_cfg", {16'h0, cfg[i] & prsdc_pkg::SCR_WMASK}, rd);
		end
		bus(1'b1, prsdc_pkg::CTRL_ADDR, 32'h0000_000f);
		foreach (scr_a[i]) poll(scr_a[i], {16'h0, cfg[i] & prsdc_pkg::SCR_WMASK | 16'h0100});
		$display("test config done");
	endtask
	task automatic t_sd;
		foreach (scr_a[i]) begin
			sd(2'(i), 26'h000_0100, 1'b0, 1'b0, lat[i]);
			sd(2'(i), 26'h000_0104, 1'b1, 1'b0, lat[i]);
			sd(2'(i), 26'h040_0100, 1'b0, 1'b0, lat[i]);
			sd(2'(i), 26'h000_0900, 1'b1, 1'b0, lat[i]);
		end
		sd(2'h0, 26'h000_0100, 1'b0, 1'b1, 2'h2);
		$display("test sdram done");
	endtask
	task automatic t_rom;
		bus(1'b1, prsdc_pkg::PROM_CFG_ADDR, 32'h0000_5003);
		bus(1'b1, prsdc_pkg::CTRL_ADDR, 32'h0000_020f);
		rom(3'h0, 26'h000_1000, 1'b0);
		rom(3'h0, 26'h000_1008, 1'b1);
		rom(3'h0, 26'h000_1018, 1'b1);
		rom(3'h0, 26'h000_1038, 1'b0);
		rom(3'h1, 26'h000_1038, 1'b0);
		rom(3'h1, 26'h000_1030, 1'b1);
		bus(1'b1, prsdc_pkg::CTRL_ADDR, 32'h0000_010f);
		rom(3'h1, 26'h000_1038, 1'b0);
		bus(1'b1, prsdc_pkg::CTRL_ADDR, 32'h0000_000f);
		rom(3'h1, 26'h000_1030, 1'b0);
		$display("test page rom done");
	endtask
	task automatic t_self;
		int n;
		repeat (1700) @(posedge MCLK);
		SELF_REF_REQ <= 1'b1;
		n = 0;
		do begin @(posedge MCLK); n++; end while (SD_CKE !== 1'b0 && n < 50);
		chk("cke_low", 0, SD_CKE);
		SELF_REF_REQ <= 1'b0;
		repeat (60) @(posedge MCLK);
		chk("cke_high", 1, SD_CKE);
		sd(2'h2, 26'h000_0200, 1'b0, 1'b0, 2'h3);
		chk("model_errors", 0, bad);
		$display("test refresh done");
	endtask
	task automatic print_verdict;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		t_reset();
		t_cfg();
		t_sd();
		t_rom();
		t_self();
		print_verdict();
	end
	initial begin
		#40000;
		err_total++;
		print_verdict();
	end
endmodule
bind prsdc_ctrl prsdc_ctrl_chk i_prsdc_ctrl_chk (.MCLK(MCLK), .RST_N(RST_N),
	.ROM_REQ(ROM_REQ), .ROM_CS(ROM_CS), .ROM_ADDR(ROM_ADDR), .ROM_ON_PAGE(ROM_ON_PAGE),
	.ROM_WAITS(ROM_WAITS), .SD_GRANT(SD_GRANT), .SD_DONE(SD_DONE), .SD_CMD(SD_CMD),
	.SD_FLYBY(SD_FLYBY), .SD_CAS_LAT(SD_CAS_LAT), .SD_CKE(SD_CKE),
	.SELF_REF_REQ(SELF_REF_REQ));
